/* File: smpc_pkg.sv */
// Package: register map, field layout and types of the serial master port
package smpc_pkg;

	// ============================================================
	// Register offsets
	localparam logic [7:0] A_FC    = 8'h00;
	localparam logic [7:0] A_NDF   = 8'h04;
	localparam logic [7:0] A_EN    = 8'h08;
	localparam logic [7:0] A_CW    = 8'h0c;
	localparam logic [7:0] A_SEL   = 8'h10;
	localparam logic [7:0] A_DIV   = 8'h14;
	localparam logic [7:0] A_TFT   = 8'h18;
	localparam logic [7:0] A_DATA  = 8'h60;
	localparam logic [7:0] A_STAT  = 8'h64;
	localparam logic [7:0] A_ISTAT = 8'h68;
	localparam logic [7:0] A_IMASK = 8'h6c;

	// ============================================================
	// Field positions
	localparam int FC_SELECT_TOGGLE_BETWEEN_FRAMES     = 24;
	localparam int FC_CFS_LSB  = 12;
	localparam int FC_TRANSFER_DIRECTION_LSB = 8;
	localparam int FC_CLOCK_IDLE_LEVEL     = 7;
	localparam int FC_CLOCK_SAMPLE_PHASE     = 6;
	localparam int FC_FRF_LSB  = 4;
	localparam int FC_DFS_LSB  = 0;
	localparam int CW_HS       = 2;
	localparam int CW_DD       = 1;
	localparam int CW_CONT     = 0;
	localparam int ST_BUSY     = 0;
	localparam int ST_LVL_LSB  = 4;
	localparam int I_TXTHR     = 0;
	localparam int I_DONE      = 1;
	localparam int I_OVF       = 2;
	localparam int IRQW        = 3;

	// ============================================================
	// Reset values, masks and encodings
	localparam logic [31:0] FC_RST   = 32'h0100_0007;
	localparam logic [31:0] FC_WMASK = 32'h0100_f3ff;
	localparam logic [1:0]  TM_BOTH  = 2'h0;
	localparam logic [1:0]  TM_TX    = 2'h1;
	localparam logic [1:0]  TM_RX    = 2'h2;
	localparam logic [1:0]  FRF_SPI  = 2'h0;
	localparam logic [1:0]  FRF_SSP  = 2'h1;
	localparam logic [1:0]  FRF_CW   = 2'h2;
	localparam logic [2:0]  SS_OFF   = 3'h7;
	localparam logic [15:0] DIV_MIN  = 16'h0002;
	localparam int          FIFO_AW  = 2;
	localparam logic [2:0]  FIFO_DEPTH = 3'h4;

	// ============================================================
	// Types
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} smpc_bus_type;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_FETCH  = 3'b001,
		S_START  = 3'b010,
		S_SYNC   = 3'b011,
		S_SHIFT  = 3'b100,
		S_HSWAIT = 3'b101,
		S_GAP    = 3'b110
	} smpc_st_type;

	// Length field to bit count: value plus one
	function automatic logic [4:0] smpc_len(input logic [3:0] v);
		smpc_len = {1'b0, v} + 5'h01;
	endfunction : smpc_len

endpackage : smpc_pkg

/* File: smpc_mem.sv */
// Transmit queue storage with registered read data
`timescale 1ns/1ns
`default_nettype none

module smpc_mem
	import smpc_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rstn,
	input  wire logic               ce,
	input  wire logic               wr_en,
	input  wire logic [FIFO_AW-1:0] wr_addr,
	input  wire logic [31:0]        wr_data,
	input  wire logic [FIFO_AW-1:0] rd_addr,
	output logic [31:0]             rd_data
);

	typedef struct packed {
		logic [(1<<FIFO_AW)-1:0][31:0] mem;
		logic [31:0]                   rd;
	} smpc_mem_state_type;

	smpc_mem_state_type s;
	smpc_mem_state_type n;

	always_comb begin
		n = s;
		n.rd = s.mem[rd_addr];
		if (wr_en) begin
			n.mem[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign rd_data = s.rd;

endmodule : smpc_mem
`default_nettype wire

/* File: smpc_top.sv */
// Serial master port: configuration registers, transmit queue and shift engine
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none


module smpc_top
	import smpc_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire smpc_bus_type bus,
	output logic [31:0]       rd_data,
	input  wire logic         miso,
	output logic              sclk,
	output logic              mosi,
	output logic [2:0]        slave_select_line_n,
	output logic              irq
);

	// ============================================================
	// State
	typedef struct packed {
		logic [31:0]     fc;
		logic [15:0]     receive_frame_count;
		logic            en;
		logic [2:0]      mw;
		logic [2:0]      sel;
		logic [15:0]     div;
		logic [1:0]      tx_interrupt_level;
		logic [IRQW-1:0] istat;
		logic [IRQW-1:0] imask;
		smpc_st_type     st;
		logic [15:0]     cnt;
		logic [4:0]      bidx;
		logic            ctl_ph;
		logic [15:0]     left;
		logic [31:0]     ent;
		logic [15:0]     rxsh;
		logic [15:0]     rxd;
		logic [1:0]      tk;
		logic [2:0]      wp;
		logic [2:0]      rp;
		logic            sclk;
		logic            mosi;
		logic [2:0]      slave_select_line;
		logic [31:0]     rdata;
		logic            irq;
		logic [1:0]      miso_sy;
	} smpc_state_type;

	smpc_state_type s;
	smpc_state_type n;

	// ============================================================
	// Decoded configuration
	logic        clock_idle_level;
	logic        clock_sample_phase;
	logic        select_toggle_between_frames;
	logic [1:0]  transfer_direction;
	logic [1:0]  frame_format_select;
	logic [4:0]  dlen;
	logic [4:0]  clen;
	logic [15:0] half;
	logic [2:0]  level;
	logic        rx_only;
	logic        quiet;
	logic        room;
	logic        push;
	logic        miso_s;
	logic [31:0] mem_rd;

	assign clock_idle_level    = s.fc[FC_CLOCK_IDLE_LEVEL];
	assign clock_sample_phase    = s.fc[FC_CLOCK_SAMPLE_PHASE];
	assign select_toggle_between_frames    = s.fc[FC_SELECT_TOGGLE_BETWEEN_FRAMES];
	assign transfer_direction    = s.fc[FC_TRANSFER_DIRECTION_LSB +: 2];
	assign frame_format_select     = s.fc[FC_FRF_LSB +: 2];
	assign dlen    = smpc_len(s.fc[FC_DFS_LSB +: 4]);
	assign clen    = smpc_len(s.fc[FC_CFS_LSB +: 4]);
	assign half    = s.div >> 1;
	assign level   = s.wp - s.rp;
	assign rx_only = transfer_direction == TM_RX;
	// Transmit side idles low when its data is not valid
	assign quiet   = rx_only || (frame_format_select == FRF_CW && !s.mw[CW_DD]);
	assign room    = level != FIFO_DEPTH;
	assign push    = bus.wr && bus.addr == A_DATA && s.en && room;
	assign miso_s  = s.miso_sy[1];

	// Bit to drive: control word sits in the upper half of an entry
	function automatic logic f_txbit(
		input logic [31:0] ent,
		input logic [4:0]  idx,
		input logic        ctl,
		input logic        q
	);
		f_txbit = (q && !ctl) ? 1'b0 : ent[{ctl, idx[3:0]}];
	endfunction : f_txbit

	// ============================================================
	// Transmit queue storage
	smpc_mem u_mem (
		.mclk    (mclk),
		.rstn    (rstn),
		.ce      (ce),
		.wr_en   (push),
		.wr_addr (s.wp[FIFO_AW-1:0]),
		.wr_data (bus.wdata),
		.rd_addr (s.rp[FIFO_AW-1:0]),
		.rd_data (mem_rd)
	);

	// ============================================================
	// Next state
	logic        lead;
	logic        trail;
	logic        last;
	logic        more;
	logic        gap_hi;
	logic [31:0] ent_new;
	logic [31:0] stat_v;

	always_comb begin
		n = s;
		n.rdata = '0;
		n.miso_sy = {s.miso_sy[0], miso};
		// Sample edge is taken two cycles late, matching the synchroniser delay
		n.tk = {s.tk[0], 1'b0};
		n.rxsh = s.tk[1] ? {s.rxsh[14:0], miso_s} : s.rxsh;
		lead = s.cnt == half - 16'h0001;
		trail = s.cnt == s.div - 16'h0001;
		last = s.bidx == 5'h00 && !s.ctl_ph;
		ent_new = rx_only ? s.ent : mem_rd;
		// Phase-0 SPI frames with select toggle deselect; control-word single mode deselects
		gap_hi = (frame_format_select == FRF_SPI && !clock_sample_phase && select_toggle_between_frames)
			|| (frame_format_select == FRF_CW && !s.mw[CW_CONT]);
		more = rx_only ? s.left != 16'h0000
			: (level != 3'h0 && (frame_format_select != FRF_CW || s.mw[CW_CONT]));
		stat_v = '0;
		stat_v[ST_LVL_LSB +: 3] = level;
		stat_v[ST_BUSY] = s.st != S_IDLE;

		// ========================================================
		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				A_FC: begin
					if (!s.en) begin
						n.fc = bus.wdata & FC_WMASK;
					end
				end
				A_NDF: begin
					if (!s.en) begin
						n.receive_frame_count = bus.wdata[15:0];
					end
				end
				A_EN: begin
					n.en = bus.wdata[0];
				end
				A_CW: begin
					if (!s.en) begin
						n.mw = bus.wdata[2:0];
					end
				end
				A_SEL: begin
					n.sel = bus.wdata[2:0];
				end
				A_DIV: begin
					if (!s.en) begin
						n.div = bus.wdata[15:0];
					end
				end
				A_TFT: begin
					n.tx_interrupt_level = bus.wdata[1:0];
				end
				A_DATA: begin
					if (push) begin
						n.wp = s.wp + 3'h1;
					end else if (s.en) begin
						n.istat[I_OVF] = 1'b1;
					end
				end
				A_ISTAT: begin
					n.istat = n.istat & ~bus.wdata[IRQW-1:0];
				end
				A_IMASK: begin
					n.imask = bus.wdata[IRQW-1:0];
				end
				default: begin
				end
			endcase
		end

		// ========================================================
		// Register reads, answer in the next cycle only
		if (bus.rd) begin
			case (bus.addr)
				A_FC:    n.rdata = s.fc;
				A_NDF:   n.rdata = {16'h0000, s.receive_frame_count};
				A_EN:    n.rdata = {31'h0, s.en};
				A_CW:    n.rdata = {29'h0, s.mw};
				A_SEL:   n.rdata = {29'h0, s.sel};
				A_DIV:   n.rdata = {16'h0000, s.div};
				A_TFT:   n.rdata = {30'h0, s.tx_interrupt_level};
				A_DATA:  n.rdata = {16'h0000, s.rxd};
				A_STAT:  n.rdata = stat_v;
				A_ISTAT: n.rdata = {29'h0, s.istat};
				A_IMASK: n.rdata = {29'h0, s.imask};
				default: n.rdata = '0;
			endcase
		end

		// ========================================================
		// Shift engine
		case (s.st)
			S_IDLE: begin
				n.sclk = clock_idle_level;
				n.slave_select_line = SS_OFF;
				n.left = (s.receive_frame_count == 16'h0000) ? 16'h0001 : s.receive_frame_count;
				// Divider below two cannot make both clock edges
				if (s.en && s.div >= DIV_MIN && level != 3'h0) begin
					n.st = S_FETCH;
				end
			end
			S_FETCH: begin
				// Receive-only: the queued word is just a start trigger
				if (rx_only) begin
					n.rp = s.rp + 3'h1;
				end
				n.st = S_START;
			end
			S_START: begin
				if (!rx_only) begin
					n.ent = mem_rd;
					n.rp = s.rp + 3'h1;
				end
				n.rxsh = '0;
				n.cnt = '0;
				n.sclk = clock_idle_level;
				n.ctl_ph = frame_format_select == FRF_CW;
				n.bidx = (frame_format_select == FRF_CW) ? clen - 5'h01 : dlen - 5'h01;
				n.slave_select_line = ~s.sel;
				n.mosi = f_txbit(ent_new, n.bidx, n.ctl_ph, quiet);
				n.st = (frame_format_select == FRF_SSP) ? S_SYNC : S_SHIFT;
			end
			S_SYNC: begin
				// One clock period of frame pulse ahead of the data
				n.cnt = s.cnt + 16'h0001;
				if (trail) begin
					n.cnt = '0;
					n.slave_select_line = SS_OFF;
					n.st = S_SHIFT;
				end
			end
			S_SHIFT: begin
				n.cnt = s.cnt + 16'h0001;
				if (lead) begin
					n.sclk = ~s.sclk;
					if (!clock_sample_phase && !s.ctl_ph) begin
						n.tk[0] = 1'b1;
					end else if (clock_sample_phase) begin
						n.mosi = f_txbit(s.ent, s.bidx, s.ctl_ph, quiet);
					end
				end
				if (trail) begin
					n.sclk = ~s.sclk;
					n.cnt = '0;
					n.tk[0] = clock_sample_phase && !s.ctl_ph;
					if (last) begin
						n.istat[I_DONE] = 1'b1;
						if (rx_only) begin
							n.left = s.left - 16'h0001;
						end
						if (frame_format_select == FRF_CW && s.mw[CW_HS] && s.mw[CW_DD]) begin
							n.st = S_HSWAIT;
						end else begin
							n.st = S_GAP;
						end
					end else begin
						if (s.bidx == 5'h00) begin
							n.ctl_ph = 1'b0;
							n.bidx = dlen - 5'h01;
						end else begin
							n.bidx = s.bidx - 5'h01;
						end
						if (!clock_sample_phase) begin
							n.mosi = f_txbit(s.ent, n.bidx, n.ctl_ph, quiet);
						end
					end
				end
			end
			S_HSWAIT: begin
				// Slave raises its output line when it has taken the word
				if (miso_s) begin
					n.st = S_GAP;
				end
			end
			S_GAP: begin
				n.cnt = s.cnt + 16'h0001;
				if (gap_hi) begin
					n.slave_select_line = SS_OFF;
				end
				if (trail) begin
					n.cnt = '0;
					// Last delayed sample has landed by now
					n.rxd = (transfer_direction != TM_TX && !(frame_format_select == FRF_CW && s.mw[CW_DD])) ? n.rxsh : s.rxd;
					if (!more) begin
						n.st = S_IDLE;
						n.slave_select_line = SS_OFF;
					end else if (rx_only) begin
						n.st = S_START;
					end else begin
						n.st = S_FETCH;
					end
				end
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase

		// ========================================================
		// Disable: stop at once, flush the queue
		if (!s.en) begin
			n.st = S_IDLE;
			n.sclk = clock_idle_level;
			n.slave_select_line = SS_OFF;
			n.wp = '0;
			n.rp = '0;
		end

		// ========================================================
		// Interrupts: hardware set wins over a same-cycle clear
		if (n.wp - n.rp <= {1'b0, s.tx_interrupt_level}) begin
			n.istat[I_TXTHR] = 1'b1;
		end
		n.irq = |(n.istat & n.imask);
	end

	// ============================================================
	// Registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.fc <= FC_RST;
			s.slave_select_line <= SS_OFF;
		end else if (ce) begin
			s <= n;
		end
	end

	assign rd_data             = s.rdata;
	assign sclk                = s.sclk;
	assign mosi                = s.mosi;
	assign slave_select_line_n = s.slave_select_line;
	assign irq                 = s.irq;

endmodule : smpc_top
`default_nettype wire

/* File: smpc_top_sva.sv */
// Checker: port-level properties of the serial master port
`timescale 1ns/1ns
`default_nettype none
module smpc_top_sva
	import smpc_pkg::*;
(
	input wire logic         mclk,
	input wire logic         rstn,
	input wire logic         ce,
	input wire smpc_bus_type bus,
	input wire logic [31:0]  rd_data,
	input wire logic         miso,
	input wire logic         sclk,
	input wire logic         mosi,
	input wire logic [2:0]   slave_select_line_n,
	input wire logic         irq
);
	// ============================================================
	// Shadow of what software wrote; locked fields follow the enable
	logic        en_r;
	logic [31:0] fc_r;
	logic [15:0] div_r;
	logic [2:0]  sel_r;
	logic [2:0]  msk_r;
	wire         wr_v = ce & bus.wr;
	wire         clock_idle_level_w = fc_r[FC_CLOCK_IDLE_LEVEL];
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			en_r <= 1'b0;
			fc_r <= FC_RST;
			div_r <= 16'h0;
			sel_r <= 3'h0;
			msk_r <= 3'h0;
		end else begin
			if (wr_v && bus.addr == A_EN)
				en_r <= bus.wdata[0];
			if (wr_v && bus.addr == A_FC && !en_r)
				fc_r <= bus.wdata & FC_WMASK;
			if (wr_v && bus.addr == A_DIV && !en_r)
				div_r <= bus.wdata[15:0];
			if (wr_v && bus.addr == A_SEL)
				sel_r <= bus.wdata[2:0];
			if (wr_v && bus.addr == A_IMASK)
				msk_r <= bus.wdata[2:0];
		end
	end
	// ============================================================
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence off_s;
		!en_r [*3];
	endsequence
	fc_lock_a: assert property (bus.rd && bus.addr == A_FC |=> rd_data == fc_r)
		else $error("frame control readback wrong");
	div_lock_a: assert property (bus.rd && bus.addr == A_DIV |=> rd_data == {16'h0, div_r})
		else $error("divider readback wrong");
	en_read_a: assert property (bus.rd && bus.addr == A_EN |=> rd_data == {31'h0, en_r})
		else $error("enable readback wrong");
	sel_read_a: assert property (bus.rd && bus.addr == A_SEL |=> rd_data == {29'h0, sel_r})
		else $error("select readback wrong");
	idle_clock_a: assert property (off_s |-> sclk == $past(clock_idle_level_w))
		else $error("serial clock not idle");
	idle_select_a: assert property (off_s |-> slave_select_line_n == SS_OFF)
		else $error("select active while disabled");
	pick_only_a: assert property ((~slave_select_line_n & ~sel_r & ~$past(sel_r)) == 3'h0)
		else $error("unpicked slave selected");
	irq_mask_a: assert property ((msk_r == 3'h0) [*2] |-> !irq)
		else $error("interrupt while fully masked");
endmodule : smpc_top_sva
bind smpc_top smpc_top_sva i_smpc_top_sva (.mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus),
	.rd_data(rd_data), .miso(miso), .sclk(sclk), .mosi(mosi),
	.slave_select_line_n(slave_select_line_n), .irq(irq));
`default_nettype wire

/* File: smpc_slave.sv */
// Behavioural serial slave answering the port
`timescale 1ns/1ns
`default_nettype none
module smpc_slave
#(
	parameter logic [15:0] REPLY = 16'ha5c3
)
(
	input  wire logic       mclk,
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic [2:0] sel_n,
	input  wire logic       clock_idle_level,
	input  wire logic       clock_sample_phase,
	output logic            miso,
	output logic [15:0]     got
);
	logic [15:0] tx_sr = REPLY;
	logic        junk = 1'b0;
	wire         none = &sel_n;
	initial got = 16'h0;
	// Released line toggles so a stale bit never looks valid
	always @(posedge mclk)
		junk <= ~junk;
	assign miso = none ? junk : tx_sr[15];
	// Phase 1 shifts out at the first edge, so preload one place late
	always @(negedge none)
		tx_sr = clock_sample_phase ? {1'b1, REPLY[15:1]} : REPLY;
	always @(sclk) begin
		if (sclk == ~(clock_idle_level ^ clock_sample_phase))
			got = {got[14:0], mosi};
		else
			tx_sr = {tx_sr[14:0], 1'b1};
	end
endmodule : smpc_slave
`default_nettype wire

/* File: smpc_bench.sv */
// Testbench: registers, frames and interrupts of the serial master port
`timescale 1ns/1ns
`default_nettype none
module smpc_bench
	import smpc_pkg::*;
;
	localparam logic [15:0] REPLY = 16'ha5c3;
	logic         mclk = 1'b0;
	logic         rstn = 1'b0;
	logic         ce = 1'b1;
	smpc_bus_type bus = '0;
	logic [31:0]  rd_data;
	logic         sclk;
	logic         mosi;
	logic         miso;
	logic         irq;
	logic [2:0]   sel_n;
	logic [15:0]  got;
	logic         pol = 1'b0;
	logic         pha = 1'b0;
	int           fails = 0;
	int           checked = 0;
	int           edges = 0;
	int           rises = 0;
	time          t1;
	time          t2;
	smpc_top i_smpc_top (.mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus), .rd_data(rd_data),
		.miso(miso), .sclk(sclk), .mosi(mosi), .slave_select_line_n(sel_n), .irq(irq));
	smpc_slave #(.REPLY(REPLY)) i_smpc_slave (.mclk(mclk), .sclk(sclk), .mosi(mosi),
		.sel_n(sel_n), .clock_idle_level(pol), .clock_sample_phase(pha), .miso(miso), .got(got));
	initial begin
		forever #5 mclk = ~mclk;
	end
	always @(sclk) begin
		if (edges == 0)
			t1 = $time;
		if (edges == 1)
			t2 = $time;
		edges++;
	end
	always @(posedge sel_n[0])
		rises++;
	// ============================================================
	// Bus and comparison helpers
	task automatic close_out;
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '0;
		@(negedge mclk);
		d = rd_data;
	endtask : rd
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		check($sformatf("reg_%h", a), v, e);
	endtask : expect_rd
	task automatic wait_idle;
		logic [31:0] s;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < 400; i++) begin
			rd(A_STAT, s);
			if (s[ST_BUSY] === 1'b0 && s[6:4] === 3'h0)
				return;
		end
		fails++;
		close_out;
	endtask : wait_idle
	// ============================================================
	// Scenarios
	task automatic s_reset_values;
		logic [7:0] a[8] = '{A_FC, A_NDF, A_EN, A_CW, A_SEL, A_DIV, A_TFT, 8'h40};
		foreach (a[i])
			expect_rd(a[i], (a[i] == A_FC) ? FC_RST : 32'h0);
	endtask : s_reset_values
	task automatic s_lock;
		logic [7:0]  a[4] = '{A_FC, A_NDF, A_CW, A_DIV};
		logic [31:0] e[4] = '{FC_WMASK, 32'hffff, 32'h7, 32'hffff};
		foreach (a[i])
			wr(a[i], 32'hffff_ffff);
		wr(A_EN, 32'h1);
		foreach (a[i])
			wr(a[i], 32'h0);
		foreach (a[i])
			expect_rd(a[i], e[i]);
		wr(A_EN, 32'h0);
	endtask : s_lock
	task automatic s_frame(input logic [1:0] f, input logic p, input logic h, input logic t,
		input logic [3:0] lc, input logic [15:0] dv, input logic [1:0] tm);
		logic [31:0] v;
		logic [31:0] m;
		int          nb;
		nb = lc + 1 + ((f == FRF_CW) ? 3 : 0);
		m = (32'h1 << nb) - 32'h1;
		wr(A_EN, 32'h0);
		wr(A_FC, {7'h0, t, 8'h0, 4'h2, 2'h0, tm, p, h, f, lc});
		wr(A_NDF, 32'h2);
		wr(A_CW, 32'h2);
		wr(A_DIV, {16'h0, dv});
		wr(A_SEL, 32'h1);
		pol = p;
		pha = h;
		wr(A_EN, 32'h1);
		edges = 0;
		rises = 0;
		wr(A_DATA, 32'h0005_0009);
		if (tm != TM_RX)
			wr(A_DATA, 32'h0005_0006);
		wait_idle;
		check("idle", sclk, p);
		if (f != FRF_SSP) begin
			check("edges", edges, 4 * nb);
			check("gaps", rises, (f == FRF_CW || (!h && t)) ? 2 : 1);
		end
		if (f == FRF_SPI)
			check("half", 32'(t2 - t1), 32'(dv * 5));
		v = (f == FRF_CW) ? ((32'h5 << (lc + 1)) | 32'h6) : 32'h6;
		if (tm != TM_RX)
			check("mosi", {16'h0, got} & m, v & m);
		if (t && !h && f == FRF_SPI) begin
			rd(A_DATA, v);
			check("reply", v & m, {16'h0, REPLY} >> (16 - nb));
		end
	endtask : s_frame
	task automatic s_irq;
		wr(A_EN, 32'h0);
		wr(A_DIV, 32'h0);
		wr(A_TFT, 32'h3);
		wr(A_IMASK, 32'h5);
		wr(A_EN, 32'h1);
		wr(A_ISTAT, 32'h7);
		repeat (5)
			wr(A_DATA, 32'h1);
		expect_rd(A_STAT, 32'h40);
		expect_rd(A_ISTAT, 32'h5);
		check("irq", irq, 1'b1);
		wr(A_ISTAT, 32'h7);
		expect_rd(A_ISTAT, 32'h0);
		check("irq", irq, 1'b0);
		wr(A_EN, 32'h0);
		expect_rd(A_STAT, 32'h0);
		expect_rd(A_ISTAT, 32'h1);
		wr(A_IMASK, 32'h0);
		expect_rd(A_ISTAT, 32'h1);
		check("irq", irq, 1'b0);
	endtask : s_irq
	initial begin
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		s_reset_values;
		s_lock;
		s_frame(FRF_SPI, 1'b0, 1'b0, 1'b1, 4'h3, 16'h4, TM_BOTH);
		s_frame(FRF_SPI, 1'b0, 1'b0, 1'b0, 4'h3, 16'h4, TM_TX);
		s_frame(FRF_SPI, 1'b1, 1'b1, 1'b0, 4'h5, 16'h6, TM_BOTH);
		s_frame(FRF_SSP, 1'b0, 1'b0, 1'b0, 4'h3, 16'h4, TM_BOTH);
		s_frame(FRF_CW, 1'b1, 1'b0, 1'b0, 4'h4, 16'h4, TM_TX);
		s_frame(FRF_SPI, 1'b0, 1'b0, 1'b1, 4'h3, 16'h4, TM_RX);
		s_irq;
		close_out;
	end
endmodule : smpc_bench
`default_nettype wire
